// >>> design/csw_pkg.sv
// package for the controller status word bank: offsets, bit positions, carriers
//
// Behaviour
// - word one bit 0 reads 1 while alarm one is active
// - word one bit 1 reads 1 while alarm two is active
// - word one bits 8 and 9 carry hardware variant detection values
// - word one bits 2-7 and 10-15 are reserved, no function
// - word two bit 0 is 1 for automatic, 0 for manual
// - word two bit 1 is 1 while running, 0 while stopped
// - word two bit 2 is 0 for direct, 1 for reverse action
// - word two bit 4 is 1 while auto-tuning runs
// - word two bits 5 and 6 show initial blocking of alarms one, two
// - word two bit 9 is 0 for Celsius, 1 for Fahrenheit
// - word two bits 11 and 12 mirror output one and output two
// - word two bits 3, 7-8, 10, 13-15 are reserved, no function
// - word three bit 0 flags process value conversion very low
// - word three bit 1 flags negative conversion after calibration
// - word three bit 2 flags process value conversion very high
// - word three bit 3 flags linearization limit exceeded
// - word three bit 4 flags excessive resistance thermometer lead resistance
// - word three bit 5 flags auto zero conversion out of range
// - word three bit 6 flags cold junction conversion out of range
package csw_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [11:0] OFF_ALARM_HW  = 12'h000;
	localparam logic [11:0] OFF_CTRL      = 12'h004;
	localparam logic [11:0] OFF_FAULT     = 12'h008;
	localparam logic [15:0] STATUS_RESET  = 16'h0000;
	localparam logic [31:0] RDATA_IDLE    = 32'h0000_0000;

	// ************************************************
	// field positions
	// ************************************************
	localparam int W1_ALARM1   = 0;
	localparam int W1_ALARM2   = 1;
	localparam int W1_HWID_LO  = 8;
	localparam int W2_AUTO     = 0;
	localparam int W2_RUN      = 1;
	localparam int W2_REVERSE  = 2;
	localparam int W2_TUNING   = 4;
	localparam int W2_BLK_AL1  = 5;
	localparam int W2_BLK_AL2  = 6;
	localparam int W2_FAHR     = 9;
	localparam int W2_OUT1     = 11;
	localparam int W2_OUT2     = 12;
	localparam int W3_PV_LOW   = 0;
	localparam int W3_NEG_CAL  = 1;
	localparam int W3_PV_HIGH  = 2;
	localparam int W3_LIN_LIM  = 3;
	localparam int W3_LEAD_RES = 4;
	localparam int W3_AZERO    = 5;
	localparam int W3_CJC      = 6;

	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic       alarm1;
		logic       alarm2;
		logic [1:0] hw_detect;
	} csw_alarm_hw_t;

	typedef struct packed {
		logic auto_mode;
		logic running;
		logic reverse_action;
		logic auto_tuning;
		logic init_block_al1;
		logic init_block_al2;
		logic fahrenheit;
		logic output1;
		logic output2;
	} csw_ctrl_t;

	typedef struct packed {
		logic pv_very_low;
		logic neg_after_cal;
		logic pv_very_high;
		logic lin_limit;
		logic lead_res_high;
		logic auto_zero_bad;
		logic cjc_bad;
	} csw_fault_t;

endpackage

// >>> design/csw_status_bank.sv
// read-only status word bank reached over apb
//
// Implementation choices: the address map and the APB register port.
module csw_status_bank
(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// status sources from the controller core
	input  wire csw_pkg::csw_alarm_hw_t alarm_hw_in,
	input  wire csw_pkg::csw_ctrl_t     ctrl_in,
	input  wire csw_pkg::csw_fault_t    fault_in
);

	// ************************************************
	// status capture
	// ************************************************
	logic [15:0] word1_q;
	logic [15:0] word2_q;
	logic [15:0] word3_q;
	logic [15:0] word1_d;
	logic [15:0] word2_d;
	logic [15:0] word3_d;

	// reserved bits stay zero because only named bits are ever set
	always_comb
	begin
		word1_d = csw_pkg::STATUS_RESET;
		word1_d[csw_pkg::W1_ALARM1] = alarm_hw_in.alarm1;
		word1_d[csw_pkg::W1_ALARM2] = alarm_hw_in.alarm2;
		word1_d[csw_pkg::W1_HWID_LO +: 2] = alarm_hw_in.hw_detect;
		word2_d = csw_pkg::STATUS_RESET;
		word2_d[csw_pkg::W2_AUTO] = ctrl_in.auto_mode;
		word2_d[csw_pkg::W2_RUN] = ctrl_in.running;
		word2_d[csw_pkg::W2_REVERSE] = ctrl_in.reverse_action;
		word2_d[csw_pkg::W2_TUNING] = ctrl_in.auto_tuning;
		word2_d[csw_pkg::W2_BLK_AL1] = ctrl_in.init_block_al1;
		word2_d[csw_pkg::W2_BLK_AL2] = ctrl_in.init_block_al2;
		word2_d[csw_pkg::W2_FAHR] = ctrl_in.fahrenheit;
		word2_d[csw_pkg::W2_OUT1] = ctrl_in.output1;
		word2_d[csw_pkg::W2_OUT2] = ctrl_in.output2;
		word3_d = csw_pkg::STATUS_RESET;
		word3_d[csw_pkg::W3_PV_LOW] = fault_in.pv_very_low;
		word3_d[csw_pkg::W3_NEG_CAL] = fault_in.neg_after_cal;
		word3_d[csw_pkg::W3_PV_HIGH] = fault_in.pv_very_high;
		word3_d[csw_pkg::W3_LIN_LIM] = fault_in.lin_limit;
		word3_d[csw_pkg::W3_LEAD_RES] = fault_in.lead_res_high;
		word3_d[csw_pkg::W3_AZERO] = fault_in.auto_zero_bad;
		word3_d[csw_pkg::W3_CJC] = fault_in.cjc_bad;
	end

	// live levels, sampled every cycle; the bus never writes them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word1_q <= csw_pkg::STATUS_RESET;
			word2_q <= csw_pkg::STATUS_RESET;
			word3_q <= csw_pkg::STATUS_RESET;
		end
		else
		begin
			word1_q <= word1_d;
			word2_q <= word2_d;
			word3_q <= word3_d;
		end
	end

	// ************************************************
	// apb slave
	// ************************************************
	logic        setup_hit;
	logic [31:0] rdata_d;
	logic        err_d;

	// answer one cycle after setup: pready is registered
	assign setup_hit = psel && !penable && !pready;

	always_comb
	begin
		rdata_d = csw_pkg::RDATA_IDLE;
		err_d   = 1'b0;
		case (paddr)
			csw_pkg::OFF_ALARM_HW: rdata_d = {16'h0000, word1_q};
			csw_pkg::OFF_CTRL:     rdata_d = {16'h0000, word2_q};
			csw_pkg::OFF_FAULT:    rdata_d = {16'h0000, word3_q};
			default:               err_d   = 1'b1;
		endcase
		// writes to mapped words are silently ignored, no error
		if (pwrite)
		begin
			rdata_d = csw_pkg::RDATA_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= csw_pkg::RDATA_IDLE;
		end
		else if (setup_hit)
		begin
			pready  <= 1'b1;
			pslverr <= err_d;
			prdata  <= rdata_d;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= csw_pkg::RDATA_IDLE;
		end
	end

endmodule

// >>> verif/controller_status_words_tb_top.sv
// self-checking bench for the status word bank
module controller_status_words_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, d, st;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, e;
	csw_pkg::csw_alarm_hw_t a_in = '0;
	csw_pkg::csw_ctrl_t c_in = '0;
	csw_pkg::csw_fault_t f_in = '0;
	int fails = 0, checks = 0;
	csw_status_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .alarm_hw_in(a_in), .ctrl_in(c_in), .fault_in(f_in));
	initial forever #4 pclk = ~pclk;
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [31:0] expw(input logic [11:0] a);
		case (a)
			12'h000: return {22'h0, a_in.hw_detect, 6'h0, a_in.alarm2, a_in.alarm1};
			12'h004: return {19'h0, c_in.output2, c_in.output1, 1'b0, c_in.fahrenheit, 2'b0,
				c_in.init_block_al2, c_in.init_block_al1, c_in.auto_tuning, 1'b0,
				c_in.reverse_action, c_in.running, c_in.auto_mode};
			12'h008: return {25'h0, f_in.cjc_bad, f_in.auto_zero_bad, f_in.lead_res_high,
				f_in.lin_limit, f_in.pv_very_high, f_in.neg_after_cal, f_in.pv_very_low};
			default: return 32'h0;
		endcase
	endfunction
	task close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [11:0] a);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, st};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 8);
		{d, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (n >= 8)
		begin
			fails++;
			close_out();
		end
	endtask
	initial
	begin
		st = 32'h5797;
		repeat (10) @(posedge pclk);
		chk(prdata | {30'h0, pready, pslverr}, 32'h0);
		presetn <= 1'b1;
		for (int i = 0; i < 30; i++)
		begin
			st = (i == 1) ? 32'hffffffff : lfsr(st);
			{a_in, c_in, f_in, pstrb} <= st[23:0];
			repeat (3) @(posedge pclk);
			for (int k = 0; k < 3; k++)
			begin
				apb(1'b0, 12'(k * 4));
				chk(d, expw(12'(k * 4)));
				chk({31'h0, e}, 32'h0);
				apb(1'b1, 12'(k * 4));
				chk(d | {31'h0, e}, 32'h0);
				apb(1'b0, 12'(k * 4));
				chk(d, expw(12'(k * 4)));
			end
			apb(st[5], 12'h00c + {st[27:20], 2'b00});
			chk({31'h0, e}, 32'h1);
			chk(d, 32'h0);
		end
		// mid-run reset: outputs clear at once, words reload on the first edge after release
		presetn <= 1'b0;
		@(posedge pclk);
		chk(prdata | {30'h0, pready, pslverr}, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, 12'h000);
		chk(d, expw(12'h000));
		close_out();
	end
endmodule

// >>> verif/csw_status_bank_monitor.sv
// protocol and field checks on the status bank ports
module csw_status_bank_monitor
(
	// clock, reset and bus
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// watched status source
	input wire csw_pkg::csw_alarm_hw_t alarm_hw_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd;
	logic map;
	assign rd = pready && !pwrite;
	assign map = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	chk_ready_answer: assert property (psel && !penable && !pready |=> pready)
		else $error("no answer");
	chk_ready_cause: assert property (pready |-> psel && penable) else $error("stray pready");
	chk_err_unmapped: assert property (pready |-> pslverr == !map) else $error("bad pslverr");
	chk_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0) else $error("wdata");
	chk_unmapped_zero: assert property (pready && !map |-> prdata == 32'h0) else $error("unmapped");
	chk_w1_reserved: assert property (rd && paddr == 12'h000 |-> !(|(prdata & 32'hfffffcfc)))
		else $error("w1 rsvd");
	chk_w2_reserved: assert property (rd && paddr == 12'h004 |-> !(|(prdata & 32'hffffe588)))
		else $error("w2 rsvd");
	chk_w3_reserved: assert property (rd && paddr == 12'h008 |-> !(|(prdata & 32'hffffff80)))
		else $error("w3 rsvd");
	chk_alarm_bits: assert property (rd && paddr == 12'h000 && $stable(alarm_hw_in)
		&& alarm_hw_in == $past(alarm_hw_in, 2) |-> prdata[1:0] == {alarm_hw_in.alarm2,
		alarm_hw_in.alarm1} && prdata[9:8] == alarm_hw_in.hw_detect)
		else $error("alarm bits");
endmodule

bind csw_status_bank csw_status_bank_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .alarm_hw_in(alarm_hw_in));
